// ### src/ast_params.svh
// Register offsets, field positions, reset values and timing counts for the sequencer timing block
`ifndef AST_PARAMS_SVH
`define AST_PARAMS_SVH

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define AST_OFS_IRQ_CFG     8'h12
`define AST_OFS_SLEEP_CFG   8'h13
`define AST_OFS_ACQ_CFG     8'h14
`define AST_OFS_PWR_CFG     8'h15
`define AST_OFS_SOFT_RESET_AND_IDENTIFIER      8'h16

// ------------------------------------------------------------------
// Field positions and values
// ------------------------------------------------------------------
`define AST_SLP_HALT_BIT    6
`define AST_SLP_DIV4_BIT    5
`define AST_SLP_MULT8_BIT   4
`define AST_SLP_WMASK       8'h77
`define AST_ACQ_WMASK       8'h1F
`define AST_PWR_CAL_BIT     7
`define AST_PWR_POL_BIT     6
`define AST_PWR_EN_BIT      5
`define AST_RESET_PATTERN   8'hAA
`define AST_CFG_RESET       8'h00
// Identifier with the low bit taken from the address select pin; value arbitrary
`define AST_DEVICE_ID_HI    7'h2B

// ------------------------------------------------------------------
// Timing (clock 100 MHz)
// ------------------------------------------------------------------
`define AST_CLK_MHZ         100
`define AST_STEP_US         2
`define AST_ACQ_BASE_US     6
`define AST_CONV_US         4
`define AST_SLEEP_BASE_US   2500
`define AST_STEP_CYC        (`AST_STEP_US * `AST_CLK_MHZ)
`define AST_ACQ_BASE_CYC    (`AST_ACQ_BASE_US * `AST_CLK_MHZ)
`define AST_CONV_CYC        (`AST_CONV_US * `AST_CLK_MHZ)
`define AST_SLEEP_BASE_CYC  (`AST_SLEEP_BASE_US * `AST_CLK_MHZ)

`endif

// ### src/ast_pkg.sv
// Types for the sequencer timing block
`default_nettype none
package ast_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_POWER_UP,
    ST_ACQUIRE,
    ST_CONVERT,
    ST_SLEEP
  } ast_phase_e;

  typedef struct packed {
    logic [7:0] irq_cfg;
    logic [7:0] sleep_cfg;
    logic [7:0] acq_cfg;
    logic [7:0] pwr_cfg;
  } ast_cfg_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ast_req_s;

endpackage : ast_pkg
`default_nettype wire

// ### src/ast_sequencer.sv
// Timing configuration registers and measurement sequencer
//
// Notes on behaviour
// - Halt bit clear: conversions continue whatever the control event status.
// - Halt bit set: stop on control event; resume only once it is cleared.
// - Irq field picks the event: 00x alarm, 01x one done, 11x four done.
// - Divider bit set divides the sleep period by four; clear gives one.
// - Multiplier bit set scales the sleep period by eight; clear gives one.
// - Base sleep code 0 is 2.5 ms, doubling per code up to 320 ms.
// - Acquisition lasts field times 2 us plus 6 us before each conversion.
// - Calibration bit set routes channel three selection to analog ground.
// - Amplifier power output active low at polarity 0, high at 1.
// - Amplifier power output disabled at enable 0, enabled at 1 in power-up, acquire and convert.
// - Power-up delay is field times 2 us; zero gives a single clock cycle.
// - Identifier read returns fixed code, low bit from address select pin.
// - Writing 10101010 to the identifier register resets the configuration registers and the sequencer.
// - Auto-scan: power-up, acquire, convert, sleep repeat once per channel.
`timescale 1ns/1ps
`default_nettype none
`include "ast_params.svh"

module ast_sequencer #(
  parameter int unsigned CHANNELS       = 4,
  parameter int unsigned SLEEP_BASE_CYC = `AST_SLEEP_BASE_CYC
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  // Register access port
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // Pin and sequencer control
  input  wire logic       bus_address_select_pin_i,
  input  wire logic       scan_run_i,
  input  wire logic       alarm_event_i,
  input  wire logic       event_clear_i,
  // Sequencer state
  output logic      [1:0] channel_o,
  output logic            converting_o,
  output logic            conv_done_o,
  output logic            scan_done_o,
  output logic            halted_o,
  output logic            channel_three_select_o,
  output logic            analog_ground_select_o,
  output logic            amp_power_control_pin_o,
  output logic            soft_reset_o
);

  // ------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------
  if (CHANNELS != 4) begin : g_chk_ch
    $error("ast_sequencer: CHANNELS must be 4");
  end
  if (SLEEP_BASE_CYC < 4) begin : g_chk_slp
    $error("ast_sequencer: SLEEP_BASE_CYC must be at least 4");
  end

  localparam int CW = 40;

  // ------------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------------
  ast_pkg::ast_cfg_s cfg_q;
  ast_pkg::ast_cfg_s cfg_d;
  logic       srst_q;
  logic       srst_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb begin
    cfg_d   = cfg_q;
    srst_d  = 1'b0;
    rdata_d = rdata_q;
    if (srst_q) begin
      cfg_d = '0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `AST_OFS_IRQ_CFG:   cfg_d.irq_cfg = reg_wdata_i;
        // Reserved bits of the sleep and acquisition registers are kept zero even if software writes them
        `AST_OFS_SLEEP_CFG: cfg_d.sleep_cfg = reg_wdata_i & `AST_SLP_WMASK;
        `AST_OFS_ACQ_CFG:   cfg_d.acq_cfg = reg_wdata_i & `AST_ACQ_WMASK;
        `AST_OFS_PWR_CFG:   cfg_d.pwr_cfg = reg_wdata_i;
        `AST_OFS_SOFT_RESET_AND_IDENTIFIER:    srst_d = (reg_wdata_i == `AST_RESET_PATTERN);
        default:            cfg_d = cfg_q;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        `AST_OFS_IRQ_CFG:   rdata_d = cfg_q.irq_cfg;
        `AST_OFS_SLEEP_CFG: rdata_d = cfg_q.sleep_cfg;
        `AST_OFS_ACQ_CFG:   rdata_d = cfg_q.acq_cfg;
        `AST_OFS_PWR_CFG:   rdata_d = cfg_q.pwr_cfg;
        `AST_OFS_SOFT_RESET_AND_IDENTIFIER:    rdata_d = {`AST_DEVICE_ID_HI, bus_address_select_pin_i};
        default:            rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_q   <= '0;
      srst_q  <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      cfg_q   <= cfg_d;
      srst_q  <= srst_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o  = rdata_q;
  assign soft_reset_o = srst_q;

  // ------------------------------------------------------------------
  // Phase lengths
  // ------------------------------------------------------------------
  logic          halt_en;
  logic [2:0]    evt_sel;
  logic [CW-1:0] pwr_len;
  logic [CW-1:0] acq_len;
  logic [CW-1:0] slp_len;

  always_comb begin
    halt_en = cfg_q.sleep_cfg[`AST_SLP_HALT_BIT];
    evt_sel = cfg_q.irq_cfg[4:2];
    pwr_len = CW'(cfg_q.pwr_cfg[4:0]) * CW'(`AST_STEP_CYC);
    acq_len = CW'(cfg_q.acq_cfg[4:0]) * CW'(`AST_STEP_CYC)
            + CW'(`AST_ACQ_BASE_CYC);
    slp_len = CW'(SLEEP_BASE_CYC) << cfg_q.sleep_cfg[2:0];
    if (cfg_q.sleep_cfg[`AST_SLP_MULT8_BIT]) begin
      slp_len = slp_len << 3;
    end
    if (cfg_q.sleep_cfg[`AST_SLP_DIV4_BIT]) begin
      slp_len = slp_len >> 2;
    end
  end

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  ast_pkg::ast_phase_e phase_q;
  ast_pkg::ast_phase_e phase_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [1:0]    ch_q;
  logic [1:0]    ch_d;
  logic          halt_q;
  logic          halt_d;
  logic          done_q;
  logic          done_d;
  logic          sdone_q;
  logic          sdone_d;
  logic          evt;

  always_comb begin
    phase_d = phase_q;
    cnt_d   = cnt_q;
    ch_d    = ch_q;
    halt_d  = halt_q;
    done_d  = 1'b0;
    sdone_d = 1'b0;
    // Event selection follows the irq configuration field
    case (evt_sel)
      3'h0, 3'h1: evt = alarm_event_i;
      3'h2, 3'h3: evt = done_q;
      3'h6, 3'h7: evt = sdone_q;
      default:    evt = 1'b0;
    endcase
    // Event wins over a clear in the same cycle; only halts when enabled
    if (halt_en && evt) begin
      halt_d = 1'b1;
    end else if (event_clear_i || !halt_en) begin
      halt_d = 1'b0;
    end
    if (srst_q || !scan_run_i) begin
      phase_d = ast_pkg::ST_IDLE;
      cnt_d   = '0;
      ch_d    = 2'h0;
      halt_d  = 1'b0;
    end else if (halt_d && phase_q != ast_pkg::ST_CONVERT) begin
      phase_d = ast_pkg::ST_IDLE;
      cnt_d   = '0;
    end else begin
      case (phase_q)
        ast_pkg::ST_IDLE: begin
          phase_d = ast_pkg::ST_POWER_UP;
          cnt_d   = pwr_len;
        end
        ast_pkg::ST_POWER_UP: begin
          if (cnt_q <= CW'(1)) begin
            phase_d = ast_pkg::ST_ACQUIRE;
            cnt_d   = acq_len;
          end else begin
            cnt_d = cnt_q - CW'(1);
          end
        end
        ast_pkg::ST_ACQUIRE: begin
          if (cnt_q <= CW'(1)) begin
            phase_d = ast_pkg::ST_CONVERT;
            cnt_d   = CW'(`AST_CONV_CYC);
          end else begin
            cnt_d = cnt_q - CW'(1);
          end
        end
        ast_pkg::ST_CONVERT: begin
          if (cnt_q <= CW'(1)) begin
            done_d  = 1'b1;
            sdone_d = (ch_q == 2'h3);
            phase_d = ast_pkg::ST_SLEEP;
            cnt_d   = slp_len;
          end else begin
            cnt_d = cnt_q - CW'(1);
          end
        end
        ast_pkg::ST_SLEEP: begin
          if (cnt_q <= CW'(1)) begin
            ch_d    = ch_q + 2'h1;
            phase_d = ast_pkg::ST_POWER_UP;
            cnt_d   = pwr_len;
          end else begin
            cnt_d = cnt_q - CW'(1);
          end
        end
        default: begin
          phase_d = ast_pkg::ST_IDLE;
          cnt_d   = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_q <= ast_pkg::ST_IDLE;
      cnt_q   <= '0;
      ch_q    <= 2'h0;
      halt_q  <= 1'b0;
      done_q  <= 1'b0;
      sdone_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      cnt_q   <= cnt_d;
      ch_q    <= ch_d;
      halt_q  <= halt_d;
      done_q  <= done_d;
      sdone_q <= sdone_d;
    end
  end

  // ------------------------------------------------------------------
  // Pin outputs
  // ------------------------------------------------------------------
  logic amp_on_q;
  logic amp_on_d;
  logic ch3_q;
  logic ch3_d;
  logic analog_ground_q;
  logic analog_ground_d;

  always_comb begin
    // Amplifier is powered through power-up, acquire and convert phases
    amp_on_d = cfg_q.pwr_cfg[`AST_PWR_EN_BIT]
             && (phase_d == ast_pkg::ST_POWER_UP || phase_d == ast_pkg::ST_ACQUIRE
                 || phase_d == ast_pkg::ST_CONVERT);
    ch3_d  = (phase_d != ast_pkg::ST_IDLE) && (ch_d == 2'h3)
           && !cfg_q.pwr_cfg[`AST_PWR_CAL_BIT];
    analog_ground_d = (phase_d != ast_pkg::ST_IDLE) && (ch_d == 2'h3)
           && cfg_q.pwr_cfg[`AST_PWR_CAL_BIT];
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      amp_on_q <= 1'b0;
      ch3_q    <= 1'b0;
      analog_ground_q   <= 1'b0;
    end else begin
      amp_on_q <= amp_on_d;
      ch3_q    <= ch3_d;
      analog_ground_q   <= analog_ground_d;
    end
  end

  // Polarity bit chooses the active level of the amplifier power pin
  assign amp_power_control_pin_o = amp_on_q ~^ cfg_q.pwr_cfg[`AST_PWR_POL_BIT];
  assign channel_three_select_o  = ch3_q;
  assign analog_ground_select_o  = analog_ground_q;
  assign channel_o               = ch_q;
  assign converting_o            = (phase_q == ast_pkg::ST_CONVERT);
  assign conv_done_o             = done_q;
  assign scan_done_o             = sdone_q;
  assign halted_o                = halt_q;

endmodule : ast_sequencer
`default_nettype wire

// ### testbench/ast_host.sv
// Host model driving the register access port
`timescale 1ns/1ps
`default_nettype none
module ast_host (
  input  wire logic       clk_i,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  input  wire logic [7:0] rdata_i
);
  initial {wr_o, rd_o, addr_o, wdata_o} = 18'h00000;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = a == 8'h13 ? d & 8'h77 : a == 8'h14 ? d & 8'h1F : d;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    wdata_o = ~wdata_o;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    rd_o = 1'b1;
    addr_o = a;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask : rd
endmodule : ast_host
`default_nettype wire

// ### testbench/ast_seq_monitor.sv
// Assertion checker on the sequencer timing ports
`timescale 1ns/1ps
`default_nettype none
`include "ast_params.svh"
module ast_seq_monitor (
  input wire logic       clk_i,
  input wire logic       arst_n_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       bus_address_select_pin_i,
  input wire logic       scan_run_i,
  input wire logic [1:0] channel_o,
  input wire logic       converting_o,
  input wire logic       conv_done_o,
  input wire logic       scan_done_o,
  input wire logic       halted_o,
  input wire logic       analog_ground_select_o,
  input wire logic       amp_power_control_pin_o,
  input wire logic       soft_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [8:0] cnt_q;
  logic [7:0] pwr_q;
  logic       halt_q;
  // Convert length counter and shadows of the config bits under watch
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q  <= 9'h000;
      pwr_q  <= 8'h00;
      halt_q <= 1'b0;
    end else begin
      cnt_q <= converting_o ? cnt_q + 9'h001 : 9'h000;
      if (soft_reset_o) begin
        pwr_q  <= 8'h00;
        halt_q <= 1'b0;
      end else if (reg_wr_i && reg_addr_i == `AST_OFS_PWR_CFG) begin
        pwr_q <= reg_wdata_i;
      end else if (reg_wr_i && reg_addr_i == `AST_OFS_SLEEP_CFG) begin
        halt_q <= reg_wdata_i[6];
      end
    end
  end
  sequence s_reset_wr;
    reg_wr_i && reg_addr_i == `AST_OFS_SOFT_RESET_AND_IDENTIFIER && reg_wdata_i == `AST_RESET_PATTERN;
  endsequence
  property p_soft; s_reset_wr |=> soft_reset_o; endproperty
  a_soft: assert property (p_soft) else $error("soft reset pulse missing");
  property p_ident;
    reg_rd_i && reg_addr_i == `AST_OFS_SOFT_RESET_AND_IDENTIFIER
      |=> reg_rdata_o == {`AST_DEVICE_ID_HI, $past(bus_address_select_pin_i)};
  endproperty
  a_ident: assert property (p_ident) else $error("identifier read wrong");
  property p_conv;
    $fell(converting_o) && scan_run_i && $past(scan_run_i) && !$past(soft_reset_o)
      |-> cnt_q == `AST_CONV_CYC;
  endproperty
  a_conv: assert property (p_conv) else $error("convert length wrong");
  property p_scan; scan_done_o |-> conv_done_o && channel_o == 2'h3; endproperty
  a_scan: assert property (p_scan) else $error("scan done off channel 3");
  property p_order;
    $changed(channel_o) && scan_run_i && $past(scan_run_i) && !$past(soft_reset_o)
      |-> channel_o == $past(channel_o) + 2'h1;
  endproperty
  a_order: assert property (p_order) else $error("channel order wrong");
  property p_halt; $rose(halted_o) |-> $past(halt_q); endproperty
  a_halt: assert property (p_halt) else $error("halt with halt bit clear");
  property p_amp;
    !scan_run_i && !$past(scan_run_i) && !$past(scan_run_i, 2) && $stable(pwr_q)
      |-> amp_power_control_pin_o == !pwr_q[6];
  endproperty
  a_amp: assert property (p_amp) else $error("amp pin not inactive");
  property p_route; analog_ground_select_o |-> $past(pwr_q[7]); endproperty
  a_route: assert property (p_route) else $error("ground route without cal");
endmodule : ast_seq_monitor
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the sequencer timing block
`timescale 1ns/1ps
`default_nettype none
`include "ast_params.svh"
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module tb;
  localparam int SB = 16;
  logic clk_i, arst_n_i, reg_wr_i, reg_rd_i, bus_address_select_pin_i, scan_run_i;
  logic alarm_event_i, event_clear_i, converting_o, conv_done_o, scan_done_o, halted_o;
  logic channel_three_select_o, analog_ground_select_o, amp_power_control_pin_o;
  logic soft_reset_o, ampv, m, d, cal, pol, en;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, v, e;
  logic [1:0] channel_o, ch;
  int fails, tests_run, n, p, a, code;
  ast_sequencer #(.SLEEP_BASE_CYC(SB)) DUT (.clk_i, .arst_n_i, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .bus_address_select_pin_i, .scan_run_i,
    .alarm_event_i, .event_clear_i, .channel_o, .converting_o, .conv_done_o, .scan_done_o,
    .halted_o, .channel_three_select_o, .analog_ground_select_o, .amp_power_control_pin_o,
    .soft_reset_o);
  ast_host host (.clk_i, .wr_o(reg_wr_i), .rd_o(reg_rd_i), .addr_o(reg_addr_i),
    .wdata_o(reg_wdata_i), .rdata_i(reg_rdata_o));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask : tick
  // Counts edges up to the next conversion pulse, noting the amp pin while converting
  task automatic wait_done(int lim);
    n = 0;
    do begin
      tick();
      n++;
      if (converting_o) ampv = amp_power_control_pin_o;
    end while (!conv_done_o && n < lim);
  endtask : wait_done
  function automatic int period(int p, int a, int c, logic m, logic d);
    return (p == 0 ? 1 : p * `AST_STEP_CYC) + a * `AST_STEP_CYC + `AST_ACQ_BASE_CYC
      + `AST_CONV_CYC + (SB << c) * (m ? 8 : 1) / (d ? 4 : 1);
  endfunction : period
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (90000) @(posedge clk_i);
    fails++;
    conclude();
  end
  initial begin
    void'($urandom(32'h55F0CD77));
    {arst_n_i, bus_address_select_pin_i, scan_run_i, alarm_event_i, event_clear_i} = 5'h00;
    repeat (2) @(posedge clk_i);
    #1;
    arst_n_i = 1'b1;
    `CHK("amp_idle", 1'b1, amp_power_control_pin_o)
    for (int i = 18; i < 23; i++) begin
      host.rd(8'(i), v);
      `CHK("reset_val", i == 22 ? {`AST_DEVICE_ID_HI, 1'b0} : 8'h00, v)
    end
    bus_address_select_pin_i = 1'b1;
    host.rd(8'h16, v);
    `CHK("ident", {`AST_DEVICE_ID_HI, 1'b1}, v)
    host.wr(8'h30, 8'h5A);
    host.rd(8'h30, v);
    `CHK("unmapped", 8'h00, v)
    repeat (6) begin
      a = 19 + $urandom % 3;
      e = 8'($urandom);
      host.wr(8'(a), e);
      host.rd(8'(a), v);
      e = a == 19 ? e & 8'h77 : a == 20 ? e & 8'h1F : e;
      `CHK("reg_rw", e, v)
    end
    for (int i = 0; i < 4; i++) begin
      {cal, pol, en, m, d} = 5'($urandom);
      m = i ? m : 1'b0;
      p = i ? $urandom % 4 : 31;
      a = i ? $urandom % 4 : 31;
      code = i ? $urandom % 4 : 7;
      host.wr(8'h12, 8'h08);
      host.wr(8'h13, {2'b00, d, m, 1'b0, 3'(code)});
      host.wr(8'h14, 8'(a));
      host.wr(8'h15, {cal, pol, en, 5'(p)});
      scan_run_i = 1'b1;
      wait_done(20000);
      ch = channel_o;
      `CHK("ground_route", ch == 2'h3 && cal, analog_ground_select_o)
      `CHK("scan_done", ch == 2'h3, scan_done_o)
      wait_done(20000);
      `CHK("period", period(p, a, code, m, d), n)
      `CHK("channel", ch + 2'h1, channel_o)
      `CHK("no_halt", 1'b0, halted_o)
      `CHK("amp_on", en ? pol : !pol, ampv)
      scan_run_i = 1'b0;
      tick();
    end
    for (int k = 0; k < 8; k++) begin
      if (k == 4 || k == 5) continue;
      host.wr(8'h12, 8'(k << 2));
      host.wr(8'h13, 8'h40);
      host.wr(8'h14, 8'h00);
      host.wr(8'h15, {k[0], 7'h00});
      scan_run_i = 1'b1;
      alarm_event_i = k < 2;
      n = 0;
      while (!halted_o && n < 6000) begin
        tick();
        n++;
      end
      alarm_event_i = 1'b0;
      `CHK("halt", 1'b1, halted_o)
      wait_done(1500);
      `CHK("held", 1'b0, conv_done_o)
      event_clear_i = 1'b1;
      tick();
      event_clear_i = 1'b0;
      wait_done(3000);
      `CHK("resume", 1'b1, conv_done_o)
      // Four-done halts leave the scan on channel 3, where the routing shows
      `CHK("resume_ch", k > 5 ? 2'h3 : 2'h0, channel_o)
      `CHK("route_ch3", k > 5 && !k[0], channel_three_select_o)
      `CHK("route_gnd", k > 5 && k[0], analog_ground_select_o)
      scan_run_i = 1'b0;
      tick();
    end
    host.wr(8'h15, 8'hE5);
    host.wr(8'h16, 8'hAA);
    `CHK("soft_pulse", 1'b1, soft_reset_o)
    tick();
    host.rd(8'h15, v);
    `CHK("soft_clear", 8'h00, v)
    conclude();
  end
endmodule : tb
bind ast_sequencer ast_seq_monitor u_mon (.clk_i, .arst_n_i, .reg_wr_i, .reg_rd_i,
  .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .bus_address_select_pin_i, .scan_run_i,
  .channel_o, .converting_o, .conv_done_o, .scan_done_o, .halted_o, .analog_ground_select_o,
  .amp_power_control_pin_o, .soft_reset_o);
`default_nettype wire
